// [sfec_seq.sv]
// serial flash array erase and page write command sequencer
// Operation
// - array erase sets all bits, needs latch
// - erase frame is opcode only, byte aligned
// - erase runs timed, then clears flag, latch
// - erase only when protect field is zero
// - page write: opcode, address, data, latch
// - only last 256 data bytes kept
// - data past page end wraps within page
// - short writes touch only the sent bytes
// - chip select must rise on byte boundary
// - page write runs timed, then clears flag, latch
// - protected page refused; upper lines ignored single
// - two-line write: data on two low lines
// - two-line write otherwise same as page write
// - four-line write needs latch; without quad enable its data comes on line zero
// - four-line write: address single, data four lines
module sfec_seq
   import sfec_pkg::*;
#(
   parameter logic [7:0] ARRAY_ERASE_OPCODE = OP_ARRAY_ERASE,
   parameter logic [7:0] FOUR_LINE_OPCODE = OP_FOUR_LINE_PAGE_WRITE,
   parameter logic [31:0] PAGE_WRITE_CYC = 32'(PAGE_WRITE_CYCLES),
   parameter logic [31:0] ARRAY_ERASE_CYC = 32'(ARRAY_ERASE_CYCLES)
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic chip_select_n_i,
   input wire logic serial_clk_i,
   input wire logic data_line_zero_i,
   input wire logic [2:0] upper_data_lines_i,
   input wire logic quad_enable_bit_i,
   input wire logic [4:0] block_protect_i,
   output logic write_in_progress_flag_o,
   output logic write_enable_latch_o,
   output logic array_write_o,
   output logic [ADDR_W-1:0] array_addr_o,
   output logic [7:0] array_wdata_o,
   output logic array_erase_o
);
   // pin synchronisers
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   logic sclk_prev;
   logic cs_prev;
   logic cs_n;
   logic [3:0] dq;
   logic sclk_rise;
   logic cs_fall;
   logic cs_rise;

   // receiver
   logic [7:0] shift;
   logic [2:0] bit_cnt;
   logic [2:0] nbytes;
   logic [7:0] opcode;
   logic [23:0] addr;
   logic overrun;
   logic addr_load;
   logic [3:0] lanes;
   logic [7:0] next_shift;
   logic [3:0] bit_sum;
   logic byte_done;
   logic prog_op;
   logic push_valid;
   logic push_ready;

   // page buffer and sequencer
   logic [7:0] page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] page_valid;
   logic [7:0] wr_ptr;
   logic [7:0] idx;
   logic [31:0] timer;
   logic [ADDR_W-9:0] page_sel;
   sfec_state_t state;
   logic fifo_valid;
   logic fifo_ready;
   logic [7:0] fifo_data;
   logic start_prog;
   logic start_erase;
   logic set_wel;

   // field[3:0]=n protects top 2^(n-1) 64k blocks, n>=7 all; field[4] mirrors to the bottom
   function automatic logic is_protected(input logic [4:0] bp, input logic [ADDR_W-1:0] a);
      logic [5:0] blk;
      logic [6:0] span;
      blk = bp[4] ? ~a[ADDR_W-1:BLOCK_LSB] : a[ADDR_W-1:BLOCK_LSB];
      span = 7'h00;
      if (bp[3:0] >= 4'h7) begin
         span = 7'h40;
      end else if (bp[3:0] != 4'h0) begin
         span = 7'(7'h01 << (bp[3:0] - 4'h1));
      end
      is_protected = ({1'b0, blk} >= (7'h40 - span)) && (span != 7'h00);
   endfunction : is_protected

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         // idle pin levels, so release of reset shows no false edge
         pin_meta <= 6'h20;
         pin_sync <= 6'h20;
         sclk_prev <= 1'b0;
         cs_prev <= 1'b1;
      end else begin
         pin_meta <= {chip_select_n_i, serial_clk_i, upper_data_lines_i, data_line_zero_i};
         pin_sync <= pin_meta;
         sclk_prev <= pin_sync[4];
         cs_prev <= pin_sync[5];
      end
   end

   assign cs_n = pin_sync[5];
   assign dq = pin_sync[3:0];
   assign sclk_rise = pin_sync[4] && !sclk_prev && !cs_n;
   assign cs_fall = !cs_n && cs_prev;
   assign cs_rise = cs_n && !cs_prev;
   assign prog_op = (opcode == OP_PAGE_WRITE) || (opcode == OP_TWO_LINE_PAGE_WRITE)
                    || (opcode == FOUR_LINE_OPCODE);

   always_comb begin
      lanes = 4'h1;
      if (nbytes >= NB_ADDR_DONE && opcode == OP_TWO_LINE_PAGE_WRITE) begin
         lanes = 4'h2;
      end else if (nbytes >= NB_ADDR_DONE && opcode == FOUR_LINE_OPCODE
                   && quad_enable_bit_i) begin
         lanes = 4'h4;
      end
      // single line reads only line zero, upper lines are don't care
      case (lanes)
         4'h2: next_shift = {shift[5:0], dq[1:0]};
         4'h4: next_shift = {shift[3:0], dq};
         default: next_shift = {shift[6:0], dq[0]};
      endcase
      bit_sum = {1'b0, bit_cnt} + lanes;
      byte_done = sclk_rise && (bit_sum == 4'h8);
   end

   // receiver only listens while idle; frames during a busy cycle are dropped
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         shift <= 8'h00;
         bit_cnt <= 3'h0;
         nbytes <= NB_NONE;
         opcode <= 8'h00;
         addr <= 24'h000000;
         addr_load <= 1'b0;
         push_valid <= 1'b0;
         overrun <= 1'b0;
      end else begin
         addr_load <= 1'b0;
         push_valid <= 1'b0;
         if (cs_fall) begin
            bit_cnt <= 3'h0;
            nbytes <= NB_NONE;
            overrun <= 1'b0;
         end else if (sclk_rise && state == SFEC_IDLE) begin
            shift <= next_shift;
            bit_cnt <= bit_sum[2:0];
            if (byte_done) begin
               if (nbytes != NB_DATA) begin
                  nbytes <= nbytes + 3'h1;
               end
               if (nbytes == NB_NONE) begin
                  opcode <= next_shift;
               end else if (nbytes <= NB_ADDR_LAST) begin
                  addr <= {addr[15:0], next_shift};
                  addr_load <= (nbytes == NB_ADDR_LAST);
               end else if (prog_op) begin
                  push_valid <= 1'b1;
               end
            end
         end
         if (push_valid && !push_ready) begin
            overrun <= 1'b1;
         end
      end
   end

   sfec_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) sfec_fifo_inst (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .in_valid_i(push_valid),
      .in_ready_o(push_ready),
      .in_data_i(shift),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_ready),
      .out_data_o(fifo_data)
   );

   // the buffer only drains before the array cycle starts
   assign fifo_ready = (state == SFEC_IDLE) || (state == SFEC_DRAIN);

   // frame check at chip select rise
   always_comb begin
      start_prog = 1'b0;
      start_erase = 1'b0;
      set_wel = 1'b0;
      if (cs_rise && state == SFEC_IDLE && bit_cnt == 3'h0) begin
         if (nbytes == NB_OPCODE && opcode == OP_WRITE_ENABLE_COMMAND) begin
            set_wel = 1'b1;
         end
         if (nbytes == NB_OPCODE && opcode == ARRAY_ERASE_OPCODE
             && write_enable_latch_o
             && block_protect_i == BP_NONE) begin
            start_erase = 1'b1;
         end
         if (nbytes == NB_DATA && prog_op && write_enable_latch_o
             && !overrun
             && !is_protected(block_protect_i, addr[ADDR_W-1:0])) begin
            start_prog = 1'b1;
         end
      end
   end

   // page buffer fill; pointer wraps inside the page
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ptr <= 8'h00;
         page_valid <= '0;
      end else begin
         if (cs_fall && state == SFEC_IDLE) begin
            page_valid <= '0;
         end else if (addr_load) begin
            wr_ptr <= shift;
         end else if (fifo_valid && fifo_ready) begin
            page_valid[wr_ptr] <= 1'b1;
            wr_ptr <= wr_ptr + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (fifo_valid && fifo_ready) begin
         page_buf[wr_ptr] <= fifo_data;
      end
   end

   // sequencer
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= SFEC_IDLE;
         idx <= 8'h00;
         timer <= 32'h0;
         page_sel <= '0;
         write_in_progress_flag_o <= 1'b0;
         write_enable_latch_o <= 1'b0;
         array_write_o <= 1'b0;
         array_addr_o <= '0;
         array_wdata_o <= 8'h00;
         array_erase_o <= 1'b0;
      end else begin
         array_write_o <= 1'b0;
         array_erase_o <= 1'b0;
         case (state)
            SFEC_IDLE: begin
               if (set_wel) begin
                  write_enable_latch_o <= 1'b1;
               end
               if (start_prog) begin
                  page_sel <= addr[ADDR_W-1:8];
                  write_in_progress_flag_o <= 1'b1;
                  state <= SFEC_DRAIN;
               end else if (start_erase) begin
                  write_in_progress_flag_o <= 1'b1;
                  state <= SFEC_ERASE;
               end
            end
            SFEC_DRAIN: begin
               idx <= 8'h00;
               if (!fifo_valid) begin
                  state <= SFEC_PROG;
               end
            end
            SFEC_PROG: begin
               // only bytes that arrived are written, the rest stay untouched
               array_write_o <= page_valid[idx];
               array_addr_o <= {page_sel, idx};
               array_wdata_o <= page_buf[idx];
               idx <= idx + 8'h01;
               if (idx == 8'hff) begin
                  timer <= PAGE_WRITE_CYC;
                  state <= SFEC_WAIT;
               end
            end
            SFEC_ERASE: begin
               array_erase_o <= 1'b1;
               timer <= ARRAY_ERASE_CYC;
               state <= SFEC_WAIT;
            end
            SFEC_WAIT: begin
               if (timer <= 32'h1) begin
                  write_in_progress_flag_o <= 1'b0;
                  write_enable_latch_o <= 1'b0;
                  state <= SFEC_IDLE;
               end else begin
                  timer <= timer - 32'h1;
               end
            end
            default: begin
               state <= SFEC_IDLE;
            end
         endcase
      end
   end
endmodule : sfec_seq

// [sfec_pkg.sv]
// constants for the serial flash erase and page write sequencer
package sfec_pkg;
   localparam int CLK_MHZ = 50;
   // self-timed cycle lengths, printed units
   localparam int PAGE_WRITE_TIME_US = 500;
   localparam int ARRAY_ERASE_TIME_MS = 2000;
   localparam int PAGE_WRITE_CYCLES = PAGE_WRITE_TIME_US * CLK_MHZ;
   localparam int ARRAY_ERASE_CYCLES = ARRAY_ERASE_TIME_MS * 1000 * CLK_MHZ;
   // opcodes
   localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
   localparam logic [7:0] OP_TWO_LINE_PAGE_WRITE = 8'ha2;
   localparam logic [7:0] OP_FOUR_LINE_PAGE_WRITE = 8'h32;
   localparam logic [7:0] OP_ARRAY_ERASE = 8'h60;
   localparam logic [7:0] OP_WRITE_ENABLE_COMMAND = 8'h06;
   // geometry
   localparam int ADDR_W = 22;
   localparam int PAGE_BYTES = 256;
   localparam int BLOCK_LSB = 16;
   localparam int FIFO_DEPTH = 32;
   // frame progress: bytes seen, saturating
   localparam logic [2:0] NB_NONE = 3'h0;
   localparam logic [2:0] NB_OPCODE = 3'h1;
   localparam logic [2:0] NB_ADDR_LAST = 3'h3;
   localparam logic [2:0] NB_ADDR_DONE = 3'h4;
   localparam logic [2:0] NB_DATA = 3'h5;
   localparam logic [4:0] BP_NONE = 5'h00;
   typedef enum logic [2:0] {
      SFEC_IDLE = 3'b000,
      SFEC_DRAIN = 3'b001,
      SFEC_PROG = 3'b010,
      SFEC_ERASE = 3'b011,
      SFEC_WAIT = 3'b100
   } sfec_state_t;
endpackage : sfec_pkg

// [sfec_fifo.sv]
// byte fifo between the serial receiver and the page buffer
module sfec_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready_o = (count != (AW + 1)'(DEPTH));
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end
endmodule : sfec_fifo

// [sfec_checker.sv]
// port assertions for the erase and page write sequencer
module sfec_checker
   import sfec_pkg::*;
#(
   parameter logic [31:0] PAGE_WRITE_CYC = 32'h14,
   parameter logic [31:0] ARRAY_ERASE_CYC = 32'h1e
) (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic chip_select_n_i,
   input wire logic [4:0] block_protect_i,
   input wire logic write_in_progress_flag_o,
   input wire logic write_enable_latch_o,
   input wire logic array_write_o,
   input wire logic [ADDR_W-1:0] array_addr_o,
   input wire logic array_erase_o
);
   localparam int E_LO = int'(ARRAY_ERASE_CYC) - 2;
   localparam int E_HI = int'(ARRAY_ERASE_CYC) + 4;
   logic [ADDR_W-1:0] prev_addr;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev_addr <= '0;
      end else begin
         prev_addr <= array_addr_o;
      end
   end
   property p_erase_hold;
      array_erase_o |=> write_in_progress_flag_o [*8];
   endproperty
   a_erase_hold: assert property (p_erase_hold) else $error("erase hold");
   property p_erase_end;
      array_erase_o |-> ##[E_LO:E_HI] $fell(write_in_progress_flag_o);
   endproperty
   a_erase_end: assert property (p_erase_end) else $error("erase length");
   property p_erase_prot;
      array_erase_o |-> block_protect_i == BP_NONE && $past(write_in_progress_flag_o);
   endproperty
   a_erase_prot: assert property (p_erase_prot) else $error("erase guard");
   property p_write_busy;
      array_write_o |-> !array_erase_o ##0 write_in_progress_flag_o [*8];
   endproperty
   a_write_busy: assert property (p_write_busy) else $error("write busy");
   property p_write_page;
      array_write_o && $past(array_write_o) |->
         array_addr_o[21:8] == prev_addr[21:8] && array_addr_o[7:0] > prev_addr[7:0];
   endproperty
   a_write_page: assert property (p_write_page) else $error("page order");
   property p_end_latch;
      $fell(write_in_progress_flag_o) |-> $fell(write_enable_latch_o);
   endproperty
   a_end_latch: assert property (p_end_latch) else $error("latch end");
   property p_start;
      $rose(write_in_progress_flag_o) |-> write_enable_latch_o && chip_select_n_i;
   endproperty
   a_start: assert property (p_start) else $error("start guard");
   property p_top_prot;
      array_write_o && block_protect_i == 5'h01 |-> array_addr_o[21:16] != 6'h3f;
   endproperty
   a_top_prot: assert property (p_top_prot) else $error("protected page");
endmodule : sfec_checker

bind sfec_seq sfec_checker #(.PAGE_WRITE_CYC(PAGE_WRITE_CYC), .ARRAY_ERASE_CYC(ARRAY_ERASE_CYC))
   sfec_checker_inst (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .chip_select_n_i(chip_select_n_i),
   .block_protect_i(block_protect_i), .write_in_progress_flag_o(write_in_progress_flag_o),
   .write_enable_latch_o(write_enable_latch_o), .array_write_o(array_write_o),
   .array_addr_o(array_addr_o), .array_erase_o(array_erase_o));

// [sfec_host.sv]
// host controller model driving the flash pins
module sfec_host (
   input wire logic sys_clk_i,
   output logic chip_select_n_o,
   output logic serial_clk_o,
   output logic [3:0] data_lines_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      chip_select_n_o = 1'h1;
      serial_clk_o = 1'h0;
      data_lines_o = 4'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : tick
   // unused lines keep toggling so the design cannot lean on them
   task automatic shift(input logic [7:0] b, input int w, input int n);
      logic [3:0] m;
      m = 4'((1 << w) - 1);
      for (int i = 8 - w; i >= 8 - n; i -= w) begin
         data_lines_o <= (4'(b >> i) & m) | (~data_lines_o & ~m);
         tick(4);
         serial_clk_o <= 1'h1;
         tick(4);
         serial_clk_o <= 1'h0;
      end
   endtask : shift
   task automatic frame(input logic [7:0] op, input int nad, input logic [23:0] ad,
         input int nd, input logic [7:0] d0, input int w, input int tail);
      chip_select_n_o <= 1'h0;
      tick(4);
      shift(op, 1, 8);
      for (int k = 2; k >= 3 - nad; k--) shift(ad[k*8 +: 8], 1, 8);
      for (int k = 0; k < nd; k++) shift(d0 + 8'(k), w, 8);
      if (tail > 0) shift(8'ha5, 1, tail);
      tick(4);
      chip_select_n_o <= 1'h1;
      data_lines_o <= ~data_lines_o;
      tick(8);
   endtask : frame
endmodule : sfec_host

// [sfec_tb.sv]
// self-checking bench for the erase and page write sequencer
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
   $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb
   import sfec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [7:0] op;
      logic [23:0] ad;
      int nd;
      int w;
      int tail;
      logic wen;
      logic [4:0] bp;
      logic ok;
   } sfec_case_t;
   sfec_case_t cases [12] = '{
      '{OP_PAGE_WRITE, 24'h001210, 3, 1, 0, 1'h1, 5'h00, 1'h1},
      '{OP_PAGE_WRITE, 24'h001300, 2, 1, 0, 1'h0, 5'h00, 1'h0},
      '{OP_FOUR_LINE_PAGE_WRITE, 24'h0020f0, 300, 4, 0, 1'h1, 5'h00, 1'h1},
      '{OP_TWO_LINE_PAGE_WRITE, 24'h0031fe, 5, 2, 0, 1'h1, 5'h00, 1'h1},
      '{OP_FOUR_LINE_PAGE_WRITE, 24'h004000, 2, 1, 0, 1'h1, 5'h00, 1'h1},
      '{OP_PAGE_WRITE, 24'h005000, 2, 1, 5, 1'h1, 5'h00, 1'h0},
      '{OP_PAGE_WRITE, 24'h005000, 0, 1, 0, 1'h1, 5'h00, 1'h0},
      '{OP_PAGE_WRITE, 24'h3f0020, 1, 1, 0, 1'h1, 5'h01, 1'h0},
      '{OP_FOUR_LINE_PAGE_WRITE, 24'h000300, 256, 4, 0, 1'h1, 5'h01, 1'h1},
      '{OP_ARRAY_ERASE, 24'h0, 0, 1, 0, 1'h1, 5'h01, 1'h0},
      '{OP_ARRAY_ERASE, 24'h0, 0, 1, 3, 1'h1, 5'h00, 1'h0},
      '{OP_ARRAY_ERASE, 24'h0, 0, 1, 0, 1'h1, 5'h00, 1'h1}
   };
   logic clk, rstn, quad_en, busy, wen_latch, wr, er, cs_n, sck, seen;
   logic [4:0] bp;
   logic [3:0] dl;
   logic [ADDR_W-1:0] addr;
   logic [7:0] wdata;
   logic [7:0] got [int];
   logic [7:0] exp_mem [int];
   int failures = 0;
   int total_checks = 0;
   int n_erase;
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   sfec_host sfec_host_inst (.sys_clk_i(clk), .chip_select_n_o(cs_n), .serial_clk_o(sck),
      .data_lines_o(dl));
   sfec_seq #(.PAGE_WRITE_CYC(32'h14), .ARRAY_ERASE_CYC(32'h1e)) sfec_seq_inst (
      .sys_clk_i(clk), .rstn_i(rstn), .chip_select_n_i(cs_n), .serial_clk_i(sck),
      .data_line_zero_i(dl[0]), .upper_data_lines_i(dl[3:1]), .quad_enable_bit_i(quad_en),
      .block_protect_i(bp), .write_in_progress_flag_o(busy), .write_enable_latch_o(wen_latch),
      .array_write_o(wr), .array_addr_o(addr), .array_wdata_o(wdata), .array_erase_o(er));
   always @(posedge clk) begin
      if (wr === 1'h1) got[int'(addr)] = wdata;
      if (er === 1'h1) n_erase++;
      if (busy === 1'h1) seen = 1'h1;
   end
   task automatic run(input sfec_case_t c);
      logic [7:0] d0;
      int i;
      d0 = c.ad[7:0] ^ 8'h5a;
      @(posedge clk);
      quad_en <= (c.w == 4);
      bp <= c.bp;
      if (c.wen) sfec_host_inst.frame(OP_WRITE_ENABLE_COMMAND, 0, 24'h0, 0, 8'h0, 1, 0);
      `CHK("latch_set", c.wen, wen_latch)
      got.delete();
      exp_mem.delete();
      n_erase = 0;
      seen = 1'h0;
      sfec_host_inst.frame(c.op, (c.op == OP_ARRAY_ERASE) ? 0 : 3, c.ad, c.nd, d0, c.w, c.tail);
      i = 0;
      while (busy !== 1'h0 && i < 400) begin
         @(posedge clk);
         i++;
      end
      // a cycle that never ends counts as a mismatch
      `CHK("idle", 1'h0, busy)
      // later bytes overwrite earlier ones at the same offset
      if (c.ok && c.op != OP_ARRAY_ERASE) begin
         for (int k = 0; k < c.nd; k++) begin
            exp_mem[int'({c.ad[21:8], c.ad[7:0] + 8'(k)})] = d0 + 8'(k);
         end
      end
      `CHK("flag", c.ok, seen)
      `CHK("latch", c.ok ? 1'h0 : c.wen, wen_latch)
      `CHK("erase", int'(c.ok && c.op == OP_ARRAY_ERASE), n_erase)
      `CHK("writes", exp_mem.num(), got.num())
      foreach (exp_mem[a]) `CHK("byte", exp_mem[a], got[a])
   endtask : run
   task automatic summarize();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize
   initial begin
      rstn = 1'h0;
      quad_en = 1'h0;
      bp = 5'h00;
      repeat (20) @(posedge clk);
      rstn <= 1'h1;
      repeat (4) @(posedge clk);
      foreach (cases[n]) run(cases[n]);
      summarize();
   end
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      summarize();
   end
endmodule : tb
